// >>> hw/dmast_pkg.sv
package dmast_pkg;
    // synchronization field encodings
    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [1:0] SYNC_SRC  = 2'h1;
    localparam logic [1:0] SYNC_DST  = 2'h2;
    localparam logic [1:0] SYNC_BOTH = 2'h3;
    // bus kind encodings for source and destination
    localparam logic [1:0] BUS_ONCHIP = 2'h0;
    localparam logic [1:0] BUS_PRIM   = 2'h1;
    localparam logic [1:0] BUS_IO     = 2'h2;
    // base access cycle counts
    localparam int ONCHIP_RD_CYC = 1;
    localparam int ONCHIP_WR_CYC = 1;
    localparam int PRIM_EXT_RD_CYC = 1;
    localparam int IO_EXT_RD_CYC = 2;
    localparam int LOAD_CYC = 1;
    localparam int EXT_WR_CYC = 2;
    // wait-state field width and cycle counter width
    localparam int WS_W  = 4;
    localparam int CNT_W = 6;
    localparam int BUF_DEPTH = 2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
endpackage

// >>> hw/dmast_buf.sv
`timescale 1ns/100ps
module dmast_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    if (DEPTH != 2) begin : g_bad_depth
        $error("dmast_buf supports depth 2 only");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic             wrPtr_q;
    logic             rdPtr_q;
    logic [1:0]       count_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q != 2'h2);
    assign outValid = (count_q != 2'h0);
    assign outData  = mem_q[rdPtr_q];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) wrPtr_q <= ~wrPtr_q;
            if (pop) rdPtr_q <= ~rdPtr_q;
            if (push && !pop) count_q <= count_q + 2'h1;
            else if (pop && !push) count_q <= count_q - 2'h1;
        end
    end
endmodule

// >>> hw/dmast_channel.sv
`timescale 1ns/100ps
// Contract
// - sync 00: read and write freely when granted, ignore interrupts
// - global interrupt masking never modifies the interrupt-enable bits
// - sync 01: each read waits for a selected interrupt
// - sync 10: read at once; write waits for a selected interrupt
// - sync 11: read on one interrupt, write on the next
// - at most one word moved per two cycles
// - two channels share buses by taking turns, never concurrently
// - on-chip read one cycle, on-chip write one cycle
// - primary bus read: external cycle plus load; write two cycles
// - io bus read: two external cycles plus load; write two cycles
// - wait states lengthen accesses; read after write adds a half cycle (here a whole cycle, external read after external write only)
// - on-chip to on-chip transfer costs two cycles
// - only latched interrupt flags synchronize the channel
// - one interrupt selected for both ends enables read and write
module dmast_channel #(
    parameter int DATA_W = 32
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_b,
    input  wire logic                        chanStart,
    input  wire logic                        chanStop,
    input  wire logic [1:0]                  syncMode,
    input  wire logic [1:0]                  srcBus,
    input  wire logic [1:0]                  dstBus,
    input  wire logic [dmast_pkg::WS_W-1:0]  read_wait_states,
    input  wire logic [dmast_pkg::WS_W-1:0]  write_wait_states,
    input  wire logic                        busGrant,
    input  wire logic                        srcIntFlag,
    input  wire logic                        dstIntFlag,
    input  wire logic                        sameIntSel,
    input  wire logic [DATA_W-1:0]           rdData,
    input  wire logic                        sinkReady,
    output logic                             rdStrobe,
    output logic                             wrStrobe,
    output logic [DATA_W-1:0]                sinkData,
    output logic                             sinkValid,
    output logic                             chanBusy,
    output logic                             intsMasked
);
    if (DATA_W < 1) begin : g_bad_width
        $error("dmast_channel needs a data width");
    end

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_RWAIT = 5'h02,
        ST_READ  = 5'h04,
        ST_WWAIT = 5'h08,
        ST_WRITE = 5'h10
    } dmast_state_t;

    localparam int CNT_W = dmast_pkg::CNT_W;

    function automatic logic [dmast_pkg::CNT_W-1:0] rdCycles(
        input logic [1:0] bk,
        input logic [dmast_pkg::WS_W-1:0] ws,
        input logic afterWr
    );
        logic [dmast_pkg::CNT_W-1:0] c;
        c = CNT_W'(dmast_pkg::ONCHIP_RD_CYC);
        // half-cycle penalty rounded up to a whole cycle at this clock
        if (bk == dmast_pkg::BUS_PRIM)
            c = CNT_W'(dmast_pkg::PRIM_EXT_RD_CYC + dmast_pkg::LOAD_CYC)
                + CNT_W'(ws) + CNT_W'(afterWr);
        else if (bk == dmast_pkg::BUS_IO)
            c = CNT_W'(dmast_pkg::IO_EXT_RD_CYC + dmast_pkg::LOAD_CYC)
                + CNT_W'(ws) + CNT_W'(afterWr);
        return c;
    endfunction

    function automatic logic [CNT_W-1:0] wrCycles(
        input logic [1:0] bk,
        input logic [dmast_pkg::WS_W-1:0] ws
    );
        logic [CNT_W-1:0] c;
        c = CNT_W'(dmast_pkg::ONCHIP_WR_CYC);
        if (bk != dmast_pkg::BUS_ONCHIP)
            c = CNT_W'(dmast_pkg::EXT_WR_CYC) + CNT_W'(ws);
        return c;
    endfunction

    dmast_state_t      state_q;
    dmast_state_t      state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic              lastWasWr_q;
    logic              wrArmed_q;
    logic              bufReady;
    logic              bufValid;
    logic [DATA_W-1:0] bufData;
    logic              rdDone;
    logic              wrDone;
    logic              sinkFree;
    logic              rdGo;
    logic              wrGo;
    logic              afterWr;
    logic              needSrcInt;
    logic              needDstInt;
    logic              cntDone;

    // only latched flags from the interrupt controller are looked at
    assign needSrcInt = (syncMode == dmast_pkg::SYNC_SRC) ||
                        (syncMode == dmast_pkg::SYNC_BOTH);
    assign needDstInt = (syncMode == dmast_pkg::SYNC_DST) ||
                        (syncMode == dmast_pkg::SYNC_BOTH);
    assign cntDone = (cnt_q == dmast_pkg::CNT_ZERO);
    assign rdDone   = (state_q == ST_READ) && cntDone;
    assign wrDone   = (state_q == ST_WRITE) && cntDone;
    // a stalled sink word must drain before the next write may land
    assign sinkFree = !sinkValid || sinkReady;
    // busGrant carries both cpu arbitration and channel time slice
    assign rdGo     = busGrant && bufReady &&
                      (!needSrcInt || srcIntFlag);
    assign wrGo     = busGrant && (bufValid || rdDone) && sinkFree &&
                      (!needDstInt || wrArmed_q);
    // half-cycle penalty counts only for a read that follows an external write
    assign afterWr  = lastWasWr_q ||
                      (wrDone && dstBus != dmast_pkg::BUS_ONCHIP);

    // no idle cycle between words: one read plus one write per word
    // already keeps the rate at or below one word per two cycles
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (chanStart) state_d = ST_RWAIT;
            end
            ST_RWAIT: begin
                if (rdGo) state_d = ST_READ;
            end
            ST_READ: begin
                if (cntDone) state_d = wrGo ? ST_WRITE : ST_WWAIT;
            end
            ST_WWAIT: begin
                if (wrGo) state_d = ST_WRITE;
            end
            ST_WRITE: begin
                // a synchronized read always waits again for a fresh flag
                if (cntDone)
                    state_d = (rdGo && !needSrcInt) ? ST_READ
                                                    : ST_RWAIT;
            end
            default: state_d = ST_IDLE;
        endcase
        if (chanStop) state_d = ST_IDLE;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) state_q <= ST_IDLE;
        else state_q <= state_d;
    end

    // access length counter; reads and writes each take >= 1 cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= dmast_pkg::CNT_ZERO;
        end else if (state_q != ST_READ && state_d == ST_READ) begin
            cnt_q <= rdCycles(srcBus, read_wait_states,
                              afterWr) - CNT_W'(1);
        end else if (state_q != ST_WRITE && state_d == ST_WRITE) begin
            cnt_q <= wrCycles(dstBus, write_wait_states)
                     - CNT_W'(1);
        end else if (!cntDone) begin
            cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) lastWasWr_q <= 1'b0;
        else if (state_q == ST_WRITE && cntDone)
            lastWasWr_q <= (dstBus != dmast_pkg::BUS_ONCHIP);
        else if (state_q == ST_READ && cntDone) lastWasWr_q <= 1'b0;
    end

    // write arming: sync 11 needs a second interrupt unless one line serves both
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrArmed_q <= 1'b0;
        end else if (state_q != ST_READ && state_d == ST_READ) begin
            wrArmed_q <= (syncMode == dmast_pkg::SYNC_BOTH) &&
                         sameIntSel;
        end else if (state_q == ST_WWAIT && dstIntFlag) begin
            wrArmed_q <= 1'b1;
        end else if (state_q == ST_WRITE) begin
            wrArmed_q <= 1'b0;
        end
    end

    // global masking is a private flag; enable bits are untouched here
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) intsMasked <= 1'b1;
        else begin
            unique case (state_d)
                ST_RWAIT: intsMasked <= !needSrcInt;
                ST_WWAIT: intsMasked <= !needDstInt;
                default:  intsMasked <= 1'b1;
            endcase
        end
    end

    dmast_buf #(
        .WIDTH (DATA_W),
        .DEPTH (dmast_pkg::BUF_DEPTH)
    ) u_buf (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .inValid  (state_q == ST_READ && cntDone),
        .inReady  (bufReady),
        .inData   (rdData),
        .outValid (bufValid),
        .outReady (state_q == ST_WRITE && cntDone),
        .outData  (bufData)
    );

    // sink stalls hold the word and stall further writes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sinkValid <= 1'b0;
            sinkData  <= '0;
        end else if (state_q == ST_WRITE && cntDone) begin
            sinkValid <= 1'b1;
            sinkData  <= bufData;
        end else if (sinkReady) begin
            sinkValid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdStrobe <= 1'b0;
            wrStrobe <= 1'b0;
            chanBusy <= 1'b0;
        end else begin
            rdStrobe <= (state_d == ST_READ);
            wrStrobe <= (state_d == ST_WRITE);
            chanBusy <= (state_d != ST_IDLE);
        end
    end
endmodule

// >>> tb/dmast_channel_props.sv
`timescale 1ns/100ps
module dmast_channel_props (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        chanStart,
    input wire logic        chanStop,
    input wire logic [1:0]  syncMode,
    input wire logic [1:0]  srcBus,
    input wire logic [1:0]  dstBus,
    input wire logic [3:0]  read_wait_states,
    input wire logic [3:0]  write_wait_states,
    input wire logic        busGrant,
    input wire logic        srcIntFlag,
    input wire logic        dstIntFlag,
    input wire logic        sameIntSel,
    input wire logic        sinkReady,
    input wire logic        rdStrobe,
    input wire logic        wrStrobe,
    input wire logic [31:0] sinkData,
    input wire logic        sinkValid,
    input wire logic        chanBusy,
    input wire logic        intsMasked
);
    int   rdN;
    int   wrN;
    logic aftQ;
    logic rdSeen;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // counts strobe length; aftQ marks a read that follows an external write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdN <= 0;
            wrN <= 0;
            aftQ <= 1'b0;
            rdSeen <= 1'b0;
        end else begin
            rdN <= rdStrobe ? rdN + 1 : 0;
            wrN <= wrStrobe ? wrN + 1 : 0;
            if (rdStrobe)
                rdSeen <= 1'b1;
            else if (wrStrobe)
                rdSeen <= 1'b0;
            if (wrStrobe && dstBus != 2'h0)
                aftQ <= 1'b1;
            else if (!rdStrobe && rdN != 0)
                aftQ <= 1'b0;
        end
    end
    a_rd_length: assert property (
        !rdStrobe && rdN != 0 && !$past(chanStop)
        && !(srcBus == 2'h0 && dstBus != 2'h0)
        |-> rdN == ((srcBus == 2'h0) ? 1 : ((srcBus == 2'h2) ? 3 : 2)
        + int'(read_wait_states) + int'(aftQ)))
        else $error("read strobe length wrong");
    a_wr_length: assert property (
        !wrStrobe && wrN != 0 && !$past(chanStop)
        |-> wrN == ((dstBus == 2'h0) ? 1 : 2 + int'(write_wait_states)))
        else $error("write strobe length wrong");
    a_no_overlap: assert property (!(rdStrobe && wrStrobe))
        else $error("read and write overlap");
    a_write_gap: assert property ($rose(wrStrobe) |-> rdSeen)
        else $error("write without a read before it");
    a_free_masked: assert property (
        syncMode == 2'h0 && $past(syncMode) == 2'h0 |-> intsMasked)
        else $error("interrupts accepted with no sync");
    a_free_start: assert property (
        syncMode == 2'h0 && chanStart && !chanBusy && busGrant && !chanStop
        |-> ##[1:3] rdStrobe) else $error("free read not issued");
    a_grant_read: assert property ($rose(rdStrobe) |-> $past(busGrant))
        else $error("read without grant");
    a_src_wait: assert property (
        $rose(rdStrobe) && syncMode[0]
        |-> $past(srcIntFlag) || $past(srcIntFlag, 2))
        else $error("read without source interrupt");
    a_dst_wait: assert property (
        $rose(wrStrobe) && syncMode[1] && !sameIntSel
        |-> $past(dstIntFlag) || $past(dstIntFlag, 2))
        else $error("write without destination interrupt");
    a_sink_hold: assert property (sinkValid && !sinkReady && !chanStop
        |=> sinkValid && $stable(sinkData)) else $error("sink word lost");
    a_stop_idle: assert property (
        chanStop |=> !rdStrobe && !wrStrobe && !chanBusy)
        else $error("stop did not abort");
endmodule
bind dmast_channel dmast_channel_props u_props (.sys_clk, .rst_b,
    .chanStart, .chanStop, .syncMode, .srcBus, .dstBus, .read_wait_states,
    .write_wait_states, .busGrant, .srcIntFlag, .dstIntFlag, .sameIntSel,
    .sinkReady, .rdStrobe, .wrStrobe, .sinkData, .sinkValid, .chanBusy,
    .intsMasked);

// >>> tb/dmast_mem_model.sv
`timescale 1ns/100ps
module dmast_mem_model (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        rdStrobe,
    input wire logic        sinkValid,
    input wire logic [31:0] sinkData,
    input wire logic        stall,
    output logic [31:0]     rdData,
    output logic            sinkReady,
    output int              gotCount,
    output int              badCount
);
    logic [31:0] wordQ;
    logic        prevQ;
    // outside a read the bus shows the inverse, so a late sample is seen
    assign rdData = rdStrobe ? wordQ : ~wordQ;
    assign sinkReady = !stall;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wordQ <= 32'ha5000000;
            prevQ <= 1'b0;
            gotCount <= 0;
            badCount <= 0;
        end else begin
            prevQ <= rdStrobe;
            if (prevQ && !rdStrobe)
                wordQ <= wordQ + 32'h1;
            if (sinkValid && sinkReady) begin
                gotCount <= gotCount + 1;
                if (sinkData !== 32'ha5000000 + 32'(gotCount))
                    badCount <= badCount + 1;
            end
        end
    end
endmodule

// >>> tb/dmast_channel_tb.sv
`timescale 1ns/100ps
module dmast_channel_tb;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        chanStart = 1'b0;
    logic        chanStop = 1'b0;
    logic [1:0]  syncMode = 2'h0;
    logic [1:0]  srcBus = 2'h0;
    logic [1:0]  dstBus = 2'h0;
    logic [3:0]  read_wait_states = 4'h0;
    logic [3:0]  write_wait_states = 4'h0;
    logic        busGrant = 1'b1;
    logic        srcIntFlag = 1'b0;
    logic        dstIntFlag = 1'b0;
    logic        sameIntSel = 1'b0;
    logic        stall = 1'b0;
    logic        rdPrev = 1'b0;
    logic [31:0] rdData;
    logic [31:0] sinkData;
    logic        sinkReady, rdStrobe, wrStrobe;
    logic        sinkValid, chanBusy, intsMasked;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          rdCount = 0;
    int          cyc = 0;
    int          lastStart = 0;
    int          period = 0;
    int          got, bad;
    dmast_channel u_dut (.sys_clk, .rst_b, .chanStart, .chanStop, .syncMode,
        .srcBus, .dstBus, .read_wait_states, .write_wait_states, .busGrant,
        .srcIntFlag, .dstIntFlag, .sameIntSel, .rdData, .sinkReady,
        .rdStrobe, .wrStrobe, .sinkData, .sinkValid, .chanBusy, .intsMasked);
    dmast_mem_model u_mem (.sys_clk, .rst_b, .rdStrobe, .sinkValid,
        .sinkData, .stall, .rdData, .sinkReady, .gotCount(got),
        .badCount(bad));
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (rdStrobe === 1'b1 && !rdPrev) begin
            rdCount = rdCount + 1;
            period = cyc - lastStart;
            lastStart = cyc;
        end
        rdPrev = rdStrobe;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask
    task automatic chk(input string what, input int exp, input int seen);
        cmp_count++;
        if (exp != seen) begin
            fail_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic chkb(input string what, input logic exp, input logic seen);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic final_report;
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic do_reset;
        rst_b = 1'b0;
        tick(10);
        rst_b = 1'b1;
        rdCount = 0;
        chkb("intsMasked", 1'b1, intsMasked);
    endtask
    task automatic start(input logic [1:0] m, s, d, input logic [3:0] r, w);
        syncMode = m;
        srcBus = s;
        dstBus = d;
        read_wait_states = r;
        write_wait_states = w;
        tick(1);
        chanStart = 1'b1;
        tick(1);
        chanStart = 1'b0;
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 500 && got < n; i++)
            tick(1);
        if (got < n) begin
            chk("words", n, got);
            final_report();
        end
    endtask
    // bus kinds: 0 on-chip, 1 primary, 2 io; no idle cycle between words
    function automatic int per(input logic [1:0] s, d, input logic [3:0] r, w);
        per = (s == 2'h0) ? 1 : ((s == 2'h2) ? dmast_pkg::IO_EXT_RD_CYC
            : dmast_pkg::PRIM_EXT_RD_CYC) + dmast_pkg::LOAD_CYC + r + (d != 0);
        if (d == 2'h0)
            per += dmast_pkg::ONCHIP_WR_CYC;
        else
            per += dmast_pkg::EXT_WR_CYC + w;
    endfunction
    task automatic t_free;
        do_reset();
        busGrant = 1'b0;
        start(2'h0, 2'h0, 2'h0, 4'h0, 4'h0);
        tick(10);
        chk("reads", 0, rdCount);
        chkb("intsMasked", 1'b1, intsMasked);
        busGrant = 1'b1;
        stall = 1'b1;
        tick(30);
        stall = 1'b0;
        wait_got(6);
        chk("order", 0, bad);
        chanStop = 1'b1;
        tick(1);
        chanStop = 1'b0;
        tick(1);
        chkb("chanBusy", 1'b0, chanBusy);
    endtask
    task automatic t_rates;
        logic [1:0] s [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
        logic [1:0] d [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
        logic [3:0] r [5] = '{4'h0, 4'h2, 4'h1, 4'h1, 4'h0};
        logic [3:0] w [5] = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h3};
        int e;
        for (int i = 0; i < 5; i++) begin
            do_reset();
            start(2'h0, s[i], d[i], r[i], w[i]);
            wait_got(4);
            e = per(s[i], d[i], r[i], w[i]);
            chk("period", e, period);
            chk("order", 0, bad);
        end
    endtask
    task automatic t_sync;
        logic [1:0] m [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
        int eR [4][3] = '{'{0, 1, 1}, '{1, 1, 2}, '{0, 1, 1}, '{0, 1, 2}};
        int eG [4][3] = '{'{0, 1, 1}, '{0, 0, 1}, '{0, 0, 1}, '{0, 1, 2}};
        for (int i = 0; i < 4; i++) begin
            do_reset();
            sameIntSel = (i == 3);
            start(m[i], 2'h0, 2'h0, 4'h0, 4'h0);
            for (int k = 0; k < 3; k++) begin
                srcIntFlag = (k == 1) || (k == 2 && i == 3);
                dstIntFlag = (k == 2);
                tick(1);
                srcIntFlag = 1'b0;
                dstIntFlag = 1'b0;
                tick(15);
                if (k == 0) chkb("intsMasked", 1'b0, intsMasked);
                chk("reads", eR[i][k], rdCount);
                chk("words", eG[i][k], got);
            end
        end
    endtask
    initial begin
        tick(1);
        t_free();
        t_rates();
        t_sync();
        final_report();
    end
endmodule
